// *** design/sat_pkg.sv ***
// constants for the scan-driven converter test control block
package sat_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 20;
    localparam int WARM_NS = 200;
    localparam int WARM_CYC = (WARM_NS * CLK_MHZ + 999) / 1000;
    localparam int DUMMY_CMPS = 10;
    localparam int READY_CYC = (DUMMY_CMPS > WARM_CYC) ? DUMMY_CMPS : WARM_CYC;
    // ****************************************
    // control cell layout, bit 0 of the chain is the comparator cell
    // ****************************************
    localparam int CTRL_W = 35;
    localparam int CHAIN_W = CTRL_W + 1;
    localparam int P_SWITCHCAP_TEST_OUT = 0;
    localparam int P_SUPPLY_REF_SELECT = 1;
    localparam int P_SETTLE = 2;
    localparam int P_CMP_LATCH_PRECHARGE_N = 3;
    localparam int P_AMP_PASSGATE_EN = 4;
    localparam int P_NEG_INPUT_SELECT = 5;
    localparam int P_MUX = 8;
    localparam int P_IREF = 16;
    localparam int P_HOLD = 17;
    localparam int P_GND = 18;
    localparam int P_EXTCH = 19;
    localparam int P_DAC = 20;
    localparam int P_AMPPWR = 30;
    localparam int P_CONVPWR = 31;
    localparam int P_BGNEG = 32;
    localparam int P_ACTEN = 33;
    localparam int P_ACLK = 34;
    // idle values: dac msb, extch, hold, mux bit 0, pass gate, precharge high
    localparam logic [34:0] CTRL_RST = 35'h0200A0118;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam logic [3:0] A_UPD_LO = 4'h8;
    localparam logic [3:0] A_UPD_HI = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sat_pkg

// *** design/sat_scan_adc.sv ***
// scan cells driving the converter control lines, with an axi4-lite status port
`timescale 1ns/1ps
`default_nettype none

// Operation
// - hold line low tracks the input, high freezes the sampled level
// - internal-reference line routes band-gap to the dac reference
// - three-bit field picks the negative input source
// - pass-gate enable opens the amplifier pass gate, idles high
// - precharge line active low, high lets the latch resolve
// - switch-cap test routes amplifier output to channel four pin
// - supply-reference line selects the supply as converter reference
// - power-on runs ten dummy comparisons; wait 200 ns before use
// - converter power-on line powers the converter, idles low
// - ground-enable ties the negative comparator input to ground
// - ten-bit dac code, msb idles high, others low
// - amplifier clock line clocks the switch-cap filters
module sat_scan_adc
    import sat_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // scan link, asynchronous to sys_clk
    input wire logic tck,
    input wire logic tdi,
    input wire logic shift_dr,
    input wire logic capture_dr,
    input wire logic update_dr,
    output logic tdo,
    // comparator from the analog side
    input wire logic cmp_out,
    // converter control lines
    output logic amp_clk,
    output logic amp_to_cmp_en,
    output logic bandgap_neg_en,
    output logic converter_power_on,
    output logic amp_power_on,
    output logic [9:0] dac_code,
    output logic bypass_ch_en,
    output logic neg_input_ground,
    output logic sample_hold,
    output logic bandgap_to_dac_ref,
    output logic [7:0] pos_input_select,
    output logic [2:0] neg_input_select,
    output logic amp_passgate_en,
    output logic cmp_latch_precharge_n,
    output logic amp_settle_assist,
    output logic supply_ref_select,
    output logic switchcap_test_out,
    output logic conv_ready,
    // axi4-lite slave
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    // ****************************************
    // synchronisers for link and comparator
    // ****************************************
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic tck3_r;
    logic tck_rise;
    logic tck_fall;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
            tck3_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= {cmp_out, update_dr, capture_dr, shift_dr, tdi, tck};
            sync2_r <= sync1_r;
            tck3_r <= sync2_r[0];
        end
    end
    assign tck_rise = sync2_r[0] & ~tck3_r;
    assign tck_fall = ~sync2_r[0] & tck3_r;

    // ****************************************
    // scan chain and update cells
    // ****************************************
    logic [35:0] chain_r;
    logic [35:0] chain_nxt;
    logic [34:0] ctrl_r;
    logic [34:0] ctrl_nxt;
    logic tdo_r;
    logic tdo_nxt;
    logic scan_en_r;
    logic [3:0] rdy_cnt_r;
    logic [3:0] rdy_cnt_nxt;
    logic ready_r;
    logic ready_nxt;
    logic pwr_d_r;
    logic conflict_r;
    logic conflict_nxt;

    // count of sources driving the negative comparator input
    function automatic logic [2:0] neg_sources(input logic [34:0] c);
        logic [2:0] n;
        n = {2'b00, |c[P_NEG_INPUT_SELECT +: 3]};
        n = n + {2'b00, c[P_GND]} + {2'b00, c[P_BGNEG]};
        return n;
    endfunction

    always_comb begin
        chain_nxt = chain_r;
        ctrl_nxt = ctrl_r;
        tdo_nxt = tdo_r;
        if (tck_rise && sync2_r[3]) begin
            chain_nxt = {ctrl_r, sync2_r[5] & ready_r};
        end else if (tck_rise && sync2_r[2]) begin
            chain_nxt = {sync2_r[1], chain_r[35:1]};
        end
        if (tck_fall && sync2_r[4] && scan_en_r) begin
            ctrl_nxt = chain_r[35:1];
        end
        if (tck_fall) begin
            tdo_nxt = chain_r[0];
        end
    end

    // warm-up: dummy comparisons and settling after power-on
    always_comb begin
        rdy_cnt_nxt = rdy_cnt_r;
        ready_nxt = ready_r;
        if (!ctrl_r[P_CONVPWR]) begin
            rdy_cnt_nxt = 4'h0;
            ready_nxt = 1'b0;
        end else if (!pwr_d_r) begin
            rdy_cnt_nxt = 4'h0;
            ready_nxt = 1'b0;
        end else if (rdy_cnt_r == 4'(READY_CYC)) begin
            ready_nxt = 1'b1;
        end else begin
            rdy_cnt_nxt = rdy_cnt_r + 4'h1;
        end
        conflict_nxt = (neg_sources(ctrl_r) > 3'h1);
    end

    // update cells reset to the idle values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_r <= 36'h000000000;
            ctrl_r <= CTRL_RST;
            tdo_r <= 1'b0;
            rdy_cnt_r <= 4'h0;
            ready_r <= 1'b0;
            pwr_d_r <= 1'b0;
            conflict_r <= 1'b0;
        end else if (clk_en) begin
            chain_r <= chain_nxt;
            ctrl_r <= ctrl_nxt;
            tdo_r <= tdo_nxt;
            rdy_cnt_r <= rdy_cnt_nxt;
            ready_r <= ready_nxt;
            pwr_d_r <= ctrl_r[P_CONVPWR];
            conflict_r <= conflict_nxt;
        end
    end

    // ****************************************
    // analog control outputs, straight from update cells
    // ****************************************
    assign tdo = tdo_r;
    assign amp_clk = ctrl_r[P_ACLK];
    assign amp_to_cmp_en = ctrl_r[P_ACTEN];
    assign bandgap_neg_en = ctrl_r[P_BGNEG];
    assign converter_power_on = ctrl_r[P_CONVPWR];
    assign amp_power_on = ctrl_r[P_AMPPWR];
    assign dac_code = ctrl_r[P_DAC +: 10];
    assign bypass_ch_en = ctrl_r[P_EXTCH];
    assign neg_input_ground = ctrl_r[P_GND];
    assign sample_hold = ctrl_r[P_HOLD];
    assign bandgap_to_dac_ref = ctrl_r[P_IREF];
    assign pos_input_select = ctrl_r[P_MUX +: 8];
    assign neg_input_select = ctrl_r[P_NEG_INPUT_SELECT +: 3];
    assign amp_passgate_en = ctrl_r[P_AMP_PASSGATE_EN];
    assign cmp_latch_precharge_n = ctrl_r[P_CMP_LATCH_PRECHARGE_N];
    assign amp_settle_assist = ctrl_r[P_SETTLE];
    assign supply_ref_select = ctrl_r[P_SUPPLY_REF_SELECT];
    assign switchcap_test_out = ctrl_r[P_SWITCHCAP_TEST_OUT];
    assign conv_ready = ready_r;

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic w_strb0_r, w_strb0_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic scan_en_nxt;

    // aw and w taken in either order, response once both are held
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb0_nxt = w_strb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        scan_en_nxt = scan_en_r;
        if (s_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = s_awaddr;
        end
        if (s_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            w_data_nxt = s_wdata;
            w_strb0_nxt = s_wstrb[0];
        end
        if (bvalid_r && s_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_full_r && w_full_r && !bvalid_r) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_SLVERR;
            if (aw_addr_r == A_CTRL) begin
                bresp_nxt = RESP_OKAY;
                if (w_strb0_r) begin
                    scan_en_nxt = w_data_r[0];
                end
            end else if (aw_addr_r == A_STATUS || aw_addr_r == A_UPD_LO || aw_addr_r == A_UPD_HI) begin
                bresp_nxt = RESP_OKAY;
            end
        end
        if (rvalid_r && s_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_araddr)
                A_CTRL: rdata_nxt = {31'h00000000, scan_en_r};
                A_STATUS: rdata_nxt = {29'h00000000, conflict_r, chain_r[0], ready_r};
                A_UPD_LO: rdata_nxt = ctrl_r[31:0];
                A_UPD_HI: rdata_nxt = {29'h00000000, ctrl_r[34:32]};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // scan updates follow only while scan_en_r is set, which reset turns on
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
            scan_en_r <= 1'b1;
        end else if (clk_en) begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb0_r <= w_strb0_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            scan_en_r <= scan_en_nxt;
        end
    end

    assign s_awready = ~aw_full_r;
    assign s_wready = ~w_full_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;
    assign s_arready = ~rvalid_r;
    assign s_rvalid = rvalid_r;
    assign s_rresp = rresp_r;
    assign s_rdata = rdata_r;
endmodule : sat_scan_adc

`default_nettype wire

// *** tb/sat_chk.sv ***
// assertion checker for the scan converter control block
`timescale 1ns/1ps
`default_nettype none
module sat_chk
    import sat_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic update_dr,
    input wire logic tdo,
    input wire logic converter_power_on,
    input wire logic conv_ready,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    input wire logic [9:0] dac_code,
    input wire logic sample_hold,
    input wire logic [7:0] pos_input_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // converter lines and scan link
    // ****************************************
    // two samples in reset so the async clear has landed
    AST_RESET_IDLE: assert property (disable iff (1'h0) !rst_n [*2] |-> dac_code == 10'h200
        && sample_hold && pos_input_select == 8'h01) else $error("idle lines wrong in reset");
    AST_UPDATE_ONLY: assert property (!update_dr [*8] |=>
        $stable({dac_code, sample_hold, pos_input_select})) else $error("lines moved without update");
    AST_TDO_STEADY: assert property ($stable(tck) [*8] |=> $stable(tdo))
        else $error("tdo moved with tck still");
    AST_READY_WARM: assert property ($rose(conv_ready) |-> $past(converter_power_on, 10))
        else $error("ready before warm-up");
    AST_READY_OFF: assert property (!converter_power_on |-> ##[1:2] !conv_ready)
        else $error("ready without power");
    // register bus answers
    AST_B_AFTER_AW: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
        else $error("no write response");
    AST_R_AFTER_AR: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid) else $error("no read data");
    AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    cover property ($rose(conv_ready));
    cover property (s_rvalid && !s_rready);
    cover property ($changed(dac_code));
endmodule : sat_chk
bind sat_scan_adc sat_chk u_chk (.sys_clk, .rst_n, .tck, .update_dr, .tdo, .converter_power_on, .conv_ready,
    .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready,
    .s_rdata, .dac_code, .sample_hold, .pos_input_select);
`default_nettype wire

// *** tb/sat_tester.sv ***
// scan tester model driving the test link
`timescale 1ns/1ps
`default_nettype none
module sat_tester
    import sat_pkg::*;
(
    input wire logic sys_clk,
    input wire logic tdo,
    output logic tck,
    output logic tdi,
    output logic shift_dr,
    output logic capture_dr,
    output logic update_dr
);
    logic smp;
    initial begin
        tck = 1'h0;
        tdi = 1'h0;
        shift_dr = 1'h0;
        capture_dr = 1'h0;
        update_dr = 1'h0;
    end
    // one 400 ns period; levels set mid-low so both edges see them settled
    task automatic pulse(input logic c, input logic s, input logic u, input logic d);
        capture_dr <= c;
        shift_dr <= s;
        update_dr <= u;
        tdi <= d;
        repeat (2) @(posedge sys_clk);
        tck <= 1'h1;
        repeat (2) @(posedge sys_clk);
        smp = tdo;
        repeat (2) @(posedge sys_clk);
        tck <= 1'h0;
        repeat (2) @(posedge sys_clk);
    endtask : pulse
    task automatic scan(input logic [35:0] din, output logic [35:0] dout);
        pulse(1'h1, 1'h0, 1'h0, ~tdi);
        for (int i = 0; i < CHAIN_W; i++) begin
            pulse(1'h0, 1'h1, 1'h0, din[i]);
            dout[i] = smp;
        end
        pulse(1'h0, 1'h0, 1'h1, ~tdi);
        repeat (2) @(posedge sys_clk);
        // idle link: clock stands low, data line turned over
        update_dr <= 1'h0;
        tdi <= ~tdi;
        @(posedge sys_clk);
    endtask : scan
endmodule : sat_tester
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the scan converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sat_pkg::*;
    logic sys_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, cmp_out = 1'h0, s_awvalid = 1'h0, s_wvalid = 1'h0;
    logic s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0, tck, tdi, shift_dr, capture_dr, update_dr, tdo;
    logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hF;
    logic [31:0] s_wdata = 32'h0, s_rdata, d;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, conv_ready, amp_clk, amp_to_cmp_en, bandgap_neg_en;
    logic converter_power_on, amp_power_on, bypass_ch_en, neg_input_ground, sample_hold, bandgap_to_dac_ref;
    logic amp_passgate_en, cmp_latch_precharge_n, amp_settle_assist, supply_ref_select, switchcap_test_out;
    logic [1:0] s_bresp, s_rresp, r;
    logic [9:0] dac_code, vin, lim;
    logic [7:0] pos_input_select;
    logic [2:0] neg_input_select;
    logic [34:0] prev, c;
    logic cbit, rdy;
    logic [35:0] so_f;
    integer seed = 32'h4781EE59;
    int errors = 0, n_checks = 0;
    sat_scan_adc u_dut (.sys_clk, .rst_n, .clk_en, .tck, .tdi, .shift_dr, .capture_dr, .update_dr, .tdo, .cmp_out,
        .amp_clk, .amp_to_cmp_en, .bandgap_neg_en, .converter_power_on, .amp_power_on, .dac_code, .bypass_ch_en,
        .neg_input_ground, .sample_hold, .bandgap_to_dac_ref, .pos_input_select, .neg_input_select,
        .amp_passgate_en, .cmp_latch_precharge_n, .amp_settle_assist, .supply_ref_select, .switchcap_test_out,
        .conv_ready, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    sat_tester u_tst (.sys_clk, .tdo, .tck, .tdi, .shift_dr, .capture_dr, .update_dr);
    initial forever #25 sys_clk = ~sys_clk;
    // measured input held at a random level from 10'h124 to 10'h142
    // comparator stand-in: high once the dac code is above the input
    always @(posedge sys_clk) cmp_out <= dac_code > vin;
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        logic ad = 1'h0;
        logic wd = 1'h0;
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
            ad |= s_awready;
            wd |= s_wready;
        end
        do @(posedge sys_clk); while (s_bvalid !== 1'h1);
        chk("bresp", s_bresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
        s_bready <= 1'h0;
        @(posedge sys_clk);
    endtask : axw
    // rready raised late on purpose so read data must stand
    task automatic axr(input logic [3:0] a);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        do @(posedge sys_clk); while (s_arready !== 1'h1);
        s_arvalid <= 1'h0;
        @(posedge sys_clk);
        s_rready <= 1'h1;
        do @(posedge sys_clk); while (s_rvalid !== 1'h1);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'h0;
        @(posedge sys_clk);
    endtask : axr
    function automatic logic [34:0] lines();
        return {amp_clk, amp_to_cmp_en, bandgap_neg_en, converter_power_on, amp_power_on, dac_code, bypass_ch_en,
            neg_input_ground, sample_hold, bandgap_to_dac_ref, pos_input_select, neg_input_select,
            amp_passgate_en, cmp_latch_precharge_n, amp_settle_assist, supply_ref_select, switchcap_test_out};
    endfunction : lines
    // turn raw bits into a setup the tester may legally apply
    function automatic logic [34:0] legal(input logic [34:0] x);
        logic [34:0] y = x;
        y[P_NEG_INPUT_SELECT+:3] = (x[34:33] != 2'h0) ? 3'h0 : (x[7:5] == 3'h0) ? 3'h1 : x[7:5];
        y[P_GND] = x[33];
        y[P_BGNEG] = x[34:33] == 2'h2;
        y[P_MUX+:8] = 8'h01 << x[2:0];
        y[P_ACTEN] = 1'h0;
        // settle assist on the load that powers the amplifier
        y[P_SETTLE] = y[P_AMPPWR] & ~prev[P_AMPPWR];
        y[P_ACLK] = y[P_ACLK] | y[P_HOLD];
        if (!y[P_HOLD]) y[P_DAC+:10] = 10'h200;
        return y;
    endfunction : legal
    task automatic load(input logic [34:0] v, input logic upd);
        logic [35:0] so;
        u_tst.scan({v, 1'h0}, so);
        repeat (6) @(posedge sys_clk);
        rdy = conv_ready;
        cbit = so[0];
        chk("captured", so[35:1], prev);
        if (upd) prev = v;
        chk("lines", lines(), prev);
        axr(A_UPD_LO);
        chk("upd_lo", d, prev[31:0]);
        axr(A_UPD_HI);
        chk("upd_hi", d, {29'h0, prev[34:32]});
    endtask : load
    // ****************************************
    // tests
    // ****************************************
    initial begin
        vin = 10'h124 + 10'($unsigned($random(seed)) % 31);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge sys_clk);
        chk("idle", lines(), CTRL_RST);
        chk("dac", dac_code, 10'h200);
        chk("cmp_latch_precharge_n", cmp_latch_precharge_n, 1'h1);
        chk("pass", amp_passgate_en, 1'h1);
        chk("pwr", converter_power_on, 1'h0);
        axr(4'h2);
        chk("unmapped", {r, d}, {RESP_SLVERR, 32'h0});
        // unmapped write refused, read-only words ignore writes
        axw(4'h6, 32'h0);
        axw(A_UPD_LO, 32'hFFFFFFFF);
        chk("ignored", lines(), CTRL_RST);
        prev = CTRL_RST;
        $display("reset test done");
        axw(A_CTRL, 32'h0);
        // byte lane 0 masked, scan enable must stay off
        s_wstrb <= 4'hE;
        axw(A_CTRL, 32'h1);
        s_wstrb <= 4'hF;
        axr(A_CTRL);
        chk("ctrl", d, 32'h0);
        load(legal('1), 1'h0);
        axw(A_CTRL, 32'h1);
        // frozen block ignores a whole scan
        clk_en <= 1'h0;
        u_tst.scan({legal('0), 1'h0}, so_f);
        clk_en <= 1'h1;
        chk("frozen", lines(), prev);
        $display("update block test done");
        for (int i = 0; i < 8; i++) load(legal(i == 0 ? '0 : i == 1 ? '1 : 35'({$random(seed), $random(seed)})), 1'h1);
        $display("random lines test done");
        c = CTRL_RST;
        c[P_CONVPWR] = 1'h0;
        load(c, 1'h1);
        c[P_CONVPWR] = 1'h1;
        c[P_MUX+:8] = 8'h08;
        // ground is the single negative source
        c[P_GND] = 1'h1;
        c[P_HOLD] = 1'h0;
        load(c, 1'h1);
        chk("cold", rdy, 1'h0);
        repeat (20) @(posedge sys_clk);
        chk("warm", conv_ready, 1'h1);
        axr(A_STATUS);
        chk("status", d, 32'h1);
        for (int k = 0; k < 2; k++) begin
            lim = k ? 10'h143 : 10'h123;
            c[P_HOLD] = 1'h1;
            load(c, 1'h1);
            c[P_DAC+:10] = lim;
            load(c, 1'h1);
            c[P_CMP_LATCH_PRECHARGE_N] = 1'h0;
            load(c, 1'h1);
            c[P_CMP_LATCH_PRECHARGE_N] = 1'h1;
            c[P_DAC+:10] = 10'h200;
            load(c, 1'h1);
            chk("window", cbit, lim > vin);
            c[P_HOLD] = 1'h0;
            load(c, 1'h1);
        end
        $display("window test done");
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        results();
    end
endmodule : tb
`default_nettype wire
